// ===== core/ldcb_pkg.sv
// Constants and carrier types for the logical device configuration bank.
// Assumes a Wishbone classic slave wrapper in ldcb_top and one system clock.
`default_nettype none
package ldcb_pkg;
   // ****************************************************************
   // Register word offsets (byte address = index times four)
   // ****************************************************************
   localparam logic [7:0] IDX_ACTIVATE = 8'h30;
   localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
   localparam logic [7:0] IDX_BASE_LOW = 8'h61;
   localparam logic [7:0] IDX_IRQ_NUMBER = 8'h70;
   localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
   localparam logic [7:0] IDX_DMA_A = 8'h74;
   localparam logic [7:0] IDX_DMA_B = 8'h75;
   localparam logic [7:0] IDX_DEV_CONFIG = 8'hF0;
   localparam logic [7:0] IDX_DRIVE_IDENTIFICATION = 8'hF1;
   // Device select field sits above the index in the word address
   localparam logic [1:0] DEV_FLOPPY = 2'h0;
   localparam logic [1:0] DEV_PARALLEL = 2'h1;
   localparam logic [1:0] DEV_SERIAL2 = 2'h2;
   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] RST_FLOPPY_CFG = 8'h24;
   localparam logic [7:0] RST_DRIVE_IDENTIFICATION = 8'h00;
   localparam logic [7:0] RST_PP_CFG = 8'hF2;
   localparam logic [7:0] RST_PP_BASE_HIGH = 8'h02;
   localparam logic [7:0] RST_PP_BASE_LOW = 8'h78;
   localparam logic [7:0] RST_PP_IRQ_NUMBER = 8'h07;
   localparam logic [7:0] RST_PP_IRQ_TYPE = 8'h02;
   localparam logic [7:0] RST_SP2_CFG = 8'h02;
   localparam logic [7:0] RST_SP2_BASE_HIGH = 8'h02;
   localparam logic [7:0] RST_SP2_BASE_LOW = 8'hF8;
   localparam logic [7:0] RST_SP2_IRQ_NUMBER = 8'h03;
   localparam logic [7:0] RST_SP2_IRQ_TYPE = 8'h03;
   localparam logic [7:0] RST_DMA = 8'h04;
   localparam logic [7:0] RST_ACTIVATE = 8'h00;
   localparam logic [7:0] NO_DMA_REPORT = 8'h04;
   // ****************************************************************
   // Field positions and masks
   // ****************************************************************
   localparam int BIT_TAPE_MODE = 6;
   localparam int BIT_DENS_POL = 5;
   localparam int BIT_FORCE_WP = 3;
   localparam int BIT_AT_MODE = 2;
   localparam int BIT_HIZ = 0;
   localparam int BIT_EXT_ACCESS = 4;
   localparam int BIT_POWER = 1;
   localparam int BIT_BANK_EN = 7;
   localparam int BIT_BUSY = 2;
   localparam int BIT_IRQ_LEVEL = 0;
   localparam int BIT_IRQ_RW = 1;
   localparam logic [7:0] FLOPPY_CFG_MASK = 8'h6F;
   localparam logic [7:0] PP_CFG_ONES = 8'hE0;
   localparam logic [7:0] PP_CFG_MASK = 8'h13;
   localparam logic [7:0] SP2_CFG_MASK = 8'h83;
   localparam logic [7:0] BASE_HIGH_MASK = 8'h07;
   localparam logic [7:0] PP_BASE_LOW_MASK = 8'hFC;
   localparam logic [7:0] SP2_BASE_LOW_MASK = 8'hF8;
   localparam logic [7:0] DRIVE_IDENTIFICATION_MASK = 8'h0F;
   localparam logic [2:0] PP_MODE_EXTENDED = 3'h3;
   localparam logic [5:0] TAPE_COMPAT_ONES = 6'h3F;

   // Control bundle driven into the functional units
   typedef struct packed {
      logic floppy_active;
      logic floppy_hiz;
      logic density_active_high;
      logic force_write_protect;
      logic at_drive_mode;
      logic pp_active;
      logic pp_hiz;
      logic pp_clock_en;
      logic pp_ext_access;
      logic sp2_active;
      logic sp2_hiz;
      logic sp2_clock_en;
      logic sp2_bank_en;
   } ldcb_ctrl_s;
endpackage : ldcb_pkg
`default_nettype wire

// ===== core/ldcb_top.sv
// Configuration bank for floppy, parallel and serial-two logical devices.
// Assumes a classic Wishbone master on clk_i and synchronous reset rst_i.
//
// Added by the designer: register access over Wishbone.
`default_nettype none
module ldcb_top (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Unit-side inputs
   input wire logic drive_one_sel_i,
   input wire logic [2:0] pp_mode_i,
   input wire logic sp2_busy_i,
   input wire logic write_protect_n_i,
   input wire logic density_high_rate_i,
   input wire logic [1:0] pp_rt_offset_i,
   input wire logic sp2_ext_access_i,
   input wire logic sp2_tx_data_i,
   // Unit-side outputs
   output logic [7:0] tape_drive_reg_o,
   output logic density_select_out_o,
   output logic write_blocked_o,
   output logic pp_ext_decode_o,
   output logic sp2_ext_decode_o,
   output logic infrared_tx_out_o,
   output ldcb_pkg::ldcb_ctrl_s ctrl_o
);
   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [7:0] fd_active; // Floppy activate
   logic [7:0] fd_cfg; // Floppy device config
   logic [7:0] drive_identification; // Drive identification
   logic [7:0] pp_act, pp_bh, pp_bl, pp_irqn, pp_irqt, pp_dma, pp_cfg;
   logic [7:0] sp_act, sp_bh, sp_bl, sp_irqn, sp_irqt, sp_rxd, sp_txd, sp_cfg;
   logic [2:0] busy_sync; // Pin synchroniser for busy
   logic [2:0] wp_sync; // Pin synchroniser for write protect
   logic busy_q; // Filtered busy level
   logic wp_n_q; // Filtered write-protect level
   logic [7:0] next_rdata;
   logic wr_stb; // Write taken this cycle
   logic [1:0] dev; // Device field of address
   logic [7:0] idx; // Register index
   logic [7:0] wd; // Write data lane 0

   assign dev = wb_adr_i[11:10];
   assign idx = wb_adr_i[9:2];
   assign wd = wb_dat_i[7:0];
   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

   // Decode helper used for floppy register writes
   function automatic logic hit(input logic [1:0] d, input logic [7:0] i,
                                input logic [1:0] wd_dev, input logic [7:0] wi);
      hit = (d == wd_dev) && (i == wi);
   endfunction : hit

   // ****************************************************************
   // Bus answer: registered ack one cycle after strobe (one wait state), ack drops next cycle
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      end
   end

   // Read data registered alongside ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_dat_o <= {24'h00_0000, next_rdata};
      end
   end

   // ****************************************************************
   // Pin synchronisers: change accepted when stages two and three agree
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_sync <= 3'h0;
         wp_sync <= 3'h7;
         busy_q <= 1'b0;
         wp_n_q <= 1'b1;
      end else begin
         busy_sync <= {busy_sync[1:0], sp2_busy_i};
         wp_sync <= {wp_sync[1:0], write_protect_n_i};
         if (busy_sync[1] == busy_sync[2]) begin
            busy_q <= busy_sync[2];
         end
         if (wp_sync[1] == wp_sync[2]) begin
            wp_n_q <= wp_sync[2];
         end
      end
   end

   // ****************************************************************
   // Floppy registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fd_active <= ldcb_pkg::RST_ACTIVATE;
         fd_cfg <= ldcb_pkg::RST_FLOPPY_CFG;
         drive_identification <= ldcb_pkg::RST_DRIVE_IDENTIFICATION;
      end else if (wr_stb) begin
         if (hit(dev, idx, ldcb_pkg::DEV_FLOPPY, ldcb_pkg::IDX_ACTIVATE)) begin
            fd_active <= wd & 8'h01;
         end
         if (hit(dev, idx, ldcb_pkg::DEV_FLOPPY, ldcb_pkg::IDX_DEV_CONFIG)) begin
            // Reserved bits held at zero
            fd_cfg <= wd & ldcb_pkg::FLOPPY_CFG_MASK;
         end
         if (hit(dev, idx, ldcb_pkg::DEV_FLOPPY, ldcb_pkg::IDX_DRIVE_IDENTIFICATION)) begin
            drive_identification <= wd & ldcb_pkg::DRIVE_IDENTIFICATION_MASK;
         end
      end
   end

   // ****************************************************************
   // Parallel port registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pp_act <= ldcb_pkg::RST_ACTIVATE;
         pp_bh <= ldcb_pkg::RST_PP_BASE_HIGH;
         pp_bl <= ldcb_pkg::RST_PP_BASE_LOW;
         pp_irqn <= ldcb_pkg::RST_PP_IRQ_NUMBER;
         pp_irqt <= ldcb_pkg::RST_PP_IRQ_TYPE;
         pp_dma <= ldcb_pkg::RST_DMA;
         pp_cfg <= ldcb_pkg::RST_PP_CFG;
      end else if (wr_stb && dev == ldcb_pkg::DEV_PARALLEL) begin
         case (idx)
            ldcb_pkg::IDX_ACTIVATE: pp_act <= wd & 8'h01;
            ldcb_pkg::IDX_BASE_HIGH: pp_bh <= wd & ldcb_pkg::BASE_HIGH_MASK;
            ldcb_pkg::IDX_BASE_LOW: pp_bl <= wd & ldcb_pkg::PP_BASE_LOW_MASK;
            ldcb_pkg::IDX_IRQ_NUMBER: pp_irqn <= wd;
            ldcb_pkg::IDX_IRQ_TYPE: pp_irqt <= wd & 8'h02;
            ldcb_pkg::IDX_DMA_A: pp_dma <= wd;
            // Reserved high bits forced to ones
            ldcb_pkg::IDX_DEV_CONFIG: begin
               pp_cfg <= (wd & ldcb_pkg::PP_CFG_MASK) | ldcb_pkg::PP_CFG_ONES;
            end
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Serial port two registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sp_act <= ldcb_pkg::RST_ACTIVATE;
         sp_bh <= ldcb_pkg::RST_SP2_BASE_HIGH;
         sp_bl <= ldcb_pkg::RST_SP2_BASE_LOW;
         sp_irqn <= ldcb_pkg::RST_SP2_IRQ_NUMBER;
         sp_irqt <= ldcb_pkg::RST_SP2_IRQ_TYPE;
         sp_rxd <= ldcb_pkg::RST_DMA;
         sp_txd <= ldcb_pkg::RST_DMA;
         sp_cfg <= ldcb_pkg::RST_SP2_CFG;
      end else if (wr_stb && dev == ldcb_pkg::DEV_SERIAL2) begin
         case (idx)
            ldcb_pkg::IDX_ACTIVATE: sp_act <= wd & 8'h01;
            ldcb_pkg::IDX_BASE_HIGH: sp_bh <= wd & ldcb_pkg::BASE_HIGH_MASK;
            ldcb_pkg::IDX_BASE_LOW: sp_bl <= wd & ldcb_pkg::SP2_BASE_LOW_MASK;
            ldcb_pkg::IDX_IRQ_NUMBER: sp_irqn <= wd;
            ldcb_pkg::IDX_IRQ_TYPE: sp_irqt <= (wd & 8'h02) | 8'h01;
            ldcb_pkg::IDX_DMA_A: sp_rxd <= wd;
            ldcb_pkg::IDX_DMA_B: sp_txd <= wd;
            ldcb_pkg::IDX_DEV_CONFIG: sp_cfg <= wd & ldcb_pkg::SP2_CFG_MASK;
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Read multiplexer
   // ****************************************************************
   always_comb begin
      next_rdata = 8'h00;
      case (dev)
         ldcb_pkg::DEV_FLOPPY: begin
            case (idx)
               ldcb_pkg::IDX_ACTIVATE: next_rdata = fd_active;
               ldcb_pkg::IDX_DEV_CONFIG: next_rdata = fd_cfg;
               ldcb_pkg::IDX_DRIVE_IDENTIFICATION: next_rdata = drive_identification;
               default: next_rdata = 8'h00;
            endcase
         end
         ldcb_pkg::DEV_PARALLEL: begin
            case (idx)
               ldcb_pkg::IDX_ACTIVATE: next_rdata = pp_act;
               ldcb_pkg::IDX_BASE_HIGH: next_rdata = pp_bh;
               ldcb_pkg::IDX_BASE_LOW: next_rdata = pp_bl;
               ldcb_pkg::IDX_IRQ_NUMBER: next_rdata = pp_irqn;
               // Level type shown in extended mode
               ldcb_pkg::IDX_IRQ_TYPE: begin
                  next_rdata = {pp_irqt[7:1], pp_mode_i == ldcb_pkg::PP_MODE_EXTENDED};
               end
               ldcb_pkg::IDX_DMA_A: next_rdata = pp_dma;
               ldcb_pkg::IDX_DMA_B: next_rdata = ldcb_pkg::NO_DMA_REPORT;
               ldcb_pkg::IDX_DEV_CONFIG: next_rdata = pp_cfg;
               default: next_rdata = 8'h00;
            endcase
         end
         ldcb_pkg::DEV_SERIAL2: begin
            case (idx)
               ldcb_pkg::IDX_ACTIVATE: next_rdata = sp_act;
               ldcb_pkg::IDX_BASE_HIGH: next_rdata = sp_bh;
               ldcb_pkg::IDX_BASE_LOW: next_rdata = sp_bl;
               ldcb_pkg::IDX_IRQ_NUMBER: next_rdata = sp_irqn;
               ldcb_pkg::IDX_IRQ_TYPE: next_rdata = sp_irqt;
               ldcb_pkg::IDX_DMA_A: next_rdata = sp_rxd;
               ldcb_pkg::IDX_DMA_B: next_rdata = sp_txd;
               // Busy bit is live hardware state
               ldcb_pkg::IDX_DEV_CONFIG: begin
                  next_rdata = sp_cfg | {5'h00, busy_q, 2'h0};
               end
               default: next_rdata = 8'h00;
            endcase
         end
         default: next_rdata = 8'h00;
      endcase
   end

   // ****************************************************************
   // Controls into the functional units
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_o <= '0;
      end else begin
         ctrl_o.floppy_active <= fd_active[0];
         ctrl_o.floppy_hiz <= ~fd_active[0] & fd_cfg[ldcb_pkg::BIT_HIZ];
         ctrl_o.density_active_high <= fd_cfg[ldcb_pkg::BIT_DENS_POL];
         ctrl_o.force_write_protect <= fd_cfg[ldcb_pkg::BIT_FORCE_WP];
         ctrl_o.at_drive_mode <= fd_cfg[ldcb_pkg::BIT_AT_MODE];
         ctrl_o.pp_active <= pp_act[0];
         ctrl_o.pp_hiz <= ~pp_act[0] & pp_cfg[ldcb_pkg::BIT_HIZ];
         ctrl_o.pp_clock_en <= pp_cfg[ldcb_pkg::BIT_POWER];
         ctrl_o.pp_ext_access <= pp_cfg[ldcb_pkg::BIT_EXT_ACCESS];
         ctrl_o.sp2_active <= sp_act[0];
         ctrl_o.sp2_hiz <= ~sp_act[0] & sp_cfg[ldcb_pkg::BIT_HIZ];
         ctrl_o.sp2_clock_en <= sp_cfg[ldcb_pkg::BIT_POWER];
         ctrl_o.sp2_bank_en <= sp_cfg[ldcb_pkg::BIT_BANK_EN];
      end
   end

   // Tape register view, density pin, write block and access gates
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tape_drive_reg_o <= 8'hFC;
         density_select_out_o <= 1'b0;
         write_blocked_o <= 1'b0;
         pp_ext_decode_o <= 1'b0;
         sp2_ext_decode_o <= 1'b0;
         infrared_tx_out_o <= 1'b0;
      end else begin
         if (!fd_cfg[ldcb_pkg::BIT_TAPE_MODE]) begin
            tape_drive_reg_o <= {ldcb_pkg::TAPE_COMPAT_ONES, 2'h0};
         end else if (drive_one_sel_i) begin
            tape_drive_reg_o <= {2'h0, drive_identification[3:2], 4'h0};
         end else begin
            tape_drive_reg_o <= {2'h0, drive_identification[1:0], 4'h0};
         end
         // Polarity flips the asserted level for the high rates
         density_select_out_o <= density_high_rate_i ~^ fd_cfg[ldcb_pkg::BIT_DENS_POL];
         write_blocked_o <= fd_cfg[ldcb_pkg::BIT_FORCE_WP] | ~wp_n_q;
         // Extended runtime registers need activation, enable and mode decode
         // Offsets 401h..403h only exist in modes up to the extended one
         pp_ext_decode_o <= pp_act[0] & pp_cfg[ldcb_pkg::BIT_EXT_ACCESS]
                            & (pp_rt_offset_i != 2'h0)
                            & (pp_mode_i <= ldcb_pkg::PP_MODE_EXTENDED);
         sp2_ext_decode_o <= sp_act[0] & sp_cfg[ldcb_pkg::BIT_BANK_EN] & sp2_ext_access_i;
         // Inactive port holds infrared low; low power gives idle level low
         infrared_tx_out_o <= sp_act[0] & sp_cfg[ldcb_pkg::BIT_POWER] & sp2_tx_data_i;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   a_floppy_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
      fd_cfg[7] == 1'b0 && fd_cfg[4] == 1'b0) else $error("floppy reserved set");
   a_tape_compat: assert property (@(posedge clk_i) disable iff (rst_i)
      !fd_cfg[6] |=> tape_drive_reg_o[7:2] == 6'h3F) else $error("tape not ones");
   a_tape_drive_identification: assert property (@(posedge clk_i) disable iff (rst_i)
      fd_cfg[6] && drive_one_sel_i |=> tape_drive_reg_o[5:4] == $past(drive_identification[3:2]))
      else $error("tape id wrong");
   a_write_force: assert property (@(posedge clk_i) disable iff (rst_i)
      fd_cfg[3] |=> write_blocked_o) else $error("write not blocked");
   a_pp_ones: assert property (@(posedge clk_i) disable iff (rst_i)
      pp_cfg[7:5] == 3'h7) else $error("parallel reserved not ones");
   a_ir_low: assert property (@(posedge clk_i) disable iff (rst_i)
      !sp_act[0] |=> !infrared_tx_out_o) else $error("infrared driven while inactive");
   a_sp2_ext_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      !sp_cfg[7] |=> !sp2_ext_decode_o) else $error("bank access while disabled");
   a_hiz_active: assert property (@(posedge clk_i) disable iff (rst_i)
      sp_act[0] |=> !ctrl_o.sp2_hiz) else $error("active device floated");
   a_base_low: assert property (@(posedge clk_i) disable iff (rst_i)
      sp_bl[2:0] == 3'h0 && pp_bl[1:0] == 2'h0) else $error("base low bits set");
   // Reset is part of the antecedent where the reset value of an output
   // differs from what the configuration would give in the release cycle
   a_dens_high: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i && fd_cfg[5] && density_high_rate_i |=> density_select_out_o)
      else $error("density select not high");
   a_dens_low: assert property (@(posedge clk_i) disable iff (rst_i)
      !fd_cfg[5] && density_high_rate_i |=> !density_select_out_o)
      else $error("density select not low");
   a_at_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i |=> ctrl_o.at_drive_mode == $past(fd_cfg[ldcb_pkg::BIT_AT_MODE]))
      else $error("drive style wrong");
   a_pp_ext_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      !pp_cfg[4] |=> !pp_ext_decode_o) else $error("extended access while disabled");
   a_pp_mode_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      pp_mode_i > ldcb_pkg::PP_MODE_EXTENDED |=> !pp_ext_decode_o)
      else $error("extended access in wrong mode");
   a_pp_inactive: assert property (@(posedge clk_i) disable iff (rst_i)
      !pp_act[0] |=> !pp_ext_decode_o) else $error("access while inactive");
   a_pp_clock: assert property (@(posedge clk_i) disable iff (rst_i)
      !rst_i |=> ctrl_o.pp_clock_en == $past(pp_cfg[ldcb_pkg::BIT_POWER]))
      else $error("parallel clock enable wrong");
   a_sp2_low_power: assert property (@(posedge clk_i) disable iff (rst_i)
      !sp_cfg[1] |=> !infrared_tx_out_o) else $error("infrared active in low power");
   a_busy_read: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o && dev == ldcb_pkg::DEV_SERIAL2
      && idx == ldcb_pkg::IDX_DEV_CONFIG |=> wb_dat_o[2] == $past(busy_q))
      else $error("busy bit wrong");
   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o && dev == ldcb_pkg::DEV_PARALLEL
      && idx == ldcb_pkg::IDX_IRQ_TYPE
      |=> wb_dat_o[0] == ($past(pp_mode_i) == ldcb_pkg::PP_MODE_EXTENDED))
      else $error("irq type bit wrong");
   c_write_cfg: cover property (@(posedge clk_i) wr_stb && idx == ldcb_pkg::IDX_DEV_CONFIG);
   c_ir_tx: cover property (@(posedge clk_i) infrared_tx_out_o);
   c_enhanced: cover property (@(posedge clk_i) fd_cfg[6] && drive_one_sel_i);
   c_busy_read: cover property (@(posedge clk_i) busy_q && wb_ack_o);
endmodule : ldcb_top
`default_nettype wire

// ===== tb/tb_ldcb_top.sv
// Self-checking bench for the configuration bank: register map over Wishbone plus unit pins.
// Assumes ldcb_pkg and ldcb_top are compiled first; one 100 MHz clock, sync reset.
`default_nettype none
module tb_ldcb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Stimulus, observed outputs and bookkeeping
   // ************************************************************
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus controls
   logic [11:0] adr = 12'h000; // Device field, index, byte lane
   logic [3:0] sel = 4'h0; // Byte lane selects
   logic [31:0] wdat = 32'h0, rdat, seed = 32'h1A; // Write data, read data, random state
   logic [2:0] mode = 3'h0; // Parallel mode from extended control
   logic [1:0] rto = 2'h0; // Runtime offset being accessed
   logic drv1 = 1'b0, busy = 1'b0, wp_n = 1'b1, rate = 1'b0, sx = 1'b0, tx = 1'b0, ack;
   logic [7:0] tape, r, v; // Tape bits, last read byte, random byte
   logic dens, wblk, ppx, spx, infrared_tx_out; // Unit-side outputs
   ldcb_pkg::ldcb_ctrl_s ctrl; // Control bundle
   int n_fail = 0, tests_run = 0; // Verdict counters
   // Register table: device, index, write value, reset value, value read back after write
   localparam logic [39:0] T [17] = '{40'h00F0FF246F, 40'h00F1FF000F, 40'h0160FF0207,
      40'h0161FF78FC, 40'h0170050705, 40'h0171FF0202, 40'h0174010401, 40'h0175000404,
      40'h01F000F2E0, 40'h0260FF0207, 40'h0261FFF8F8, 40'h02700A030A, 40'h0271000301,
      40'h0274020402, 40'h0275030403, 40'h02F0FF0283, 40'h0050FF0000};

   // Clock
   always #5 clk_i = ~clk_i;

   ldcb_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .drive_one_sel_i(drv1), .pp_mode_i(mode), .sp2_busy_i(busy), .write_protect_n_i(wp_n),
      .density_high_rate_i(rate), .pp_rt_offset_i(rto), .sp2_ext_access_i(sx),
      .sp2_tx_data_i(tx), .tape_drive_reg_o(tape), .density_select_out_o(dens),
      .write_blocked_o(wblk), .pp_ext_decode_o(ppx), .sp2_ext_decode_o(spx),
      .infrared_tx_out_o(infrared_tx_out), .ctrl_o(ctrl));

   // ************************************************************
   // Helpers
   // ************************************************************
   // Xorshift generator, repeatable from the fixed seed
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   // Drive_identification pair expected on the tape bits for the selected drive
   function automatic logic [1:0] id_pair(input logic [7:0] id, input logic d1);
      return d1 ? id[3:2] : id[1:0];
   endfunction : id_pair

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Print counts and verdict, then stop
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up

   // One classic cycle; returns at the edge where ack was sampled
   task automatic wb(input logic [1:0] d, input logic [7:0] i, input logic w, input logic [7:0] x);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= {d, i, 2'h0};
      wdat <= {24'h0, x};
      repeat (20) begin
         @(posedge clk_i);
         if (ack === 1'b1) break;
      end
      if (ack !== 1'b1) begin
         n_fail++;
         wrap_up();
      end else begin
         r = rdat[7:0];
         cyc <= 1'b0;
         stb <= 1'b0;
         we <= 1'b0;
         sel <= 4'h0;
      end
   endtask : wb

   // Read and compare one register
   task automatic rc(input logic [1:0] d, input logic [7:0] i, input logic [7:0] e);
      wb(d, i, 1'b0, 8'h00);
      chk(r, e);
   endtask : rc

   // Let registered outputs settle, sample at the falling edge
   task automatic st(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask : st

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk(tape, 8'hFC);
      chk({19'h0, ctrl}, 32'h0);
      for (int d = 0; d < 3; d++) begin
         rc(d[1:0], 8'h30, 8'h00);
         wb(d[1:0], 8'h30, 1'b1, 8'hFF);
         rc(d[1:0], 8'h30, 8'h01);
      end
      $display("test activate done");
      foreach (T[e]) begin
         rc(T[e][33:32], T[e][31:24], T[e][15:8]);
         wb(T[e][33:32], T[e][31:24], 1'b1, T[e][23:16]);
         rc(T[e][33:32], T[e][31:24], T[e][7:0]);
      end
      $display("test register map done");
      mode <= ldcb_pkg::PP_MODE_EXTENDED;
      rc(2'h1, 8'h71, 8'h03);
      mode <= 3'h1;
      rc(2'h1, 8'h71, 8'h02);
      wb(2'h0, 8'hF0, 1'b1, 8'h00);
      v = rnd();
      rate <= v[0];
      st(3);
      chk(dens, {31'h0, ~rate});
      chk(ctrl.at_drive_mode, 1'b0);
      chk(wblk, 1'b0);
      chk(tape[7:2], 6'h3F);
      wb(2'h0, 8'hF0, 1'b1, 8'h24);
      st(2);
      chk(dens, rate);
      chk(ctrl.at_drive_mode, 1'b1);
      @(posedge clk_i);
      wp_n <= 1'b0;
      st(6);
      chk(wblk, 1'b1);
      @(posedge clk_i);
      wp_n <= 1'b1;
      wb(2'h0, 8'hF0, 1'b1, 8'h08);
      st(6);
      chk(wblk, 1'b1);
      $display("test floppy controls done");
      wb(2'h0, 8'hF0, 1'b1, 8'h40);
      repeat (4) begin
         v = rnd();
         wb(2'h0, 8'hF1, 1'b1, v);
         drv1 <= v[4];
         st(2);
         chk(tape[5:4], id_pair(v, v[4]));
      end
      // Non-sensing drives marked through ID bits 3 and 1
      wb(2'h0, 8'hF1, 1'b1, 8'h0A);
      drv1 <= 1'b0;
      st(2);
      chk(tape[5], 1'b1);
      @(posedge clk_i);
      drv1 <= 1'b1;
      st(2);
      chk(tape[5], 1'b1);
      $display("test tape bits done");
      wb(2'h1, 8'hF0, 1'b1, 8'hE0);
      rto <= 2'h2;
      st(2);
      chk(ppx, 1'b0);
      chk(ctrl.pp_clock_en, 1'b0);
      wb(2'h1, 8'hF0, 1'b1, 8'hF2);
      st(2);
      chk(ppx, 1'b1);
      chk(ctrl.pp_clock_en, 1'b1);
      @(posedge clk_i);
      mode <= 3'h4;
      st(2);
      chk(ppx, 1'b0);
      wb(2'h2, 8'hF0, 1'b1, 8'h83);
      sx <= 1'b1;
      st(2);
      chk(spx, 1'b1);
      wb(2'h2, 8'hF0, 1'b1, 8'h03);
      busy <= 1'b1;
      st(2);
      chk(spx, 1'b0);
      st(4);
      rc(2'h2, 8'hF0, 8'h07);
      busy <= 1'b0;
      tx <= 1'b1;
      st(6);
      rc(2'h2, 8'hF0, 8'h03);
      st(1);
      chk(infrared_tx_out, 1'b1);
      wb(2'h2, 8'hF0, 1'b1, 8'h01);
      st(2);
      chk(infrared_tx_out, 1'b0);
      chk(ctrl.sp2_clock_en, 1'b0);
      rc(2'h2, 8'hF0, 8'h01);
      wb(2'h2, 8'hF0, 1'b1, 8'h03);
      wb(2'h0, 8'hF0, 1'b1, 8'h01);
      wb(2'h1, 8'hF0, 1'b1, 8'hE3);
      for (int d = 0; d < 3; d++) begin
         wb(d[1:0], 8'h30, 1'b1, 8'h00);
      end
      st(2);
      chk(infrared_tx_out, 1'b0);
      chk({ctrl.floppy_hiz, ctrl.pp_hiz, ctrl.sp2_hiz}, 3'h7);
      wb(2'h0, 8'h30, 1'b1, 8'h01);
      st(2);
      chk({ctrl.floppy_active, ctrl.floppy_hiz}, 2'h2);
      chk({19'h0, ctrl}, 32'h1066);
      $display("test unit controls done");
      wrap_up();
   end
endmodule : tb_ldcb_top
`default_nettype wire
